// *** stat_counters_pkg.sv ***
// Shared constants for the MAC error statistics counters.
package stat_counters_pkg;

    // ======================================================
    // Register offsets in the host register space
    // ======================================================
    localparam logic [7:0] OFS_OVERSIZE = 8'hc8;
    localparam logic [7:0] OFS_LENGTH   = 8'hca;
    localparam logic [7:0] OFS_TARDY    = 8'he8;
    localparam logic [7:0] OFS_PAUSE    = 8'hf8;

    // ======================================================
    // Mask bit positions, one per counter
    // ======================================================
    localparam int MASK_OVERSIZE = 0;
    localparam int MASK_LENGTH   = 1;
    localparam int MASK_TARDY    = 2;
    localparam int MASK_PAUSE    = 3;
    localparam int NUM_COUNTERS  = 4;

    // ======================================================
    // Reset values and thresholds
    // ======================================================
    localparam logic [15:0] RST_OVERSIZE = 16'h0000;
    localparam logic [15:0] RST_LENGTH   = 16'h0000;
    localparam logic [31:0] RST_TARDY    = 32'h00000000;
    localparam logic [15:0] RST_PAUSE    = 16'h0000;
    localparam logic [15:0] THRESH_16    = 16'hc000;
    localparam logic [31:0] THRESH_32    = 32'hc0000000;

    // ======================================================
    // Frame constants and timing
    // ======================================================
    localparam logic [15:0] PAUSE_OPCODE      = 16'h0001;
    localparam int          MIN_CLIENT_OCTETS = 46;
    localparam int          MAX_CLIENT_OCTETS = 1500;
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          SLOT_TIME_NS      = 4096;
    localparam int          SLOT_CYCLES       = SLOT_TIME_NS / CLK_PERIOD_NS;

endpackage : stat_counters_pkg

// *** stat_counter.sv ***
// One wrapping statistics counter with software load and threshold pulse.
`timescale 1ns/1ps
module stat_counter #(
    parameter int         W       = 16,
    parameter logic [W-1:0] RST_VAL = '0,
    parameter logic [W-1:0] THRESH  = '1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Count and load
    input  wire logic         countEvent,
    input  wire logic         loadEn,
    input  wire logic [W-1:0] loadValue,
    // State
    output logic      [W-1:0] countValue,
    output logic              thresholdHit
);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;

    if (W < 2) begin : g_bad_width
        $error("stat_counter width too small");
    end

    // All-ones plus one wraps to zero by width truncation.
    assign count_d = count_q + W'(1);

    // A software load wins over a same-cycle event; the event is dropped.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= RST_VAL;
        end else if (loadEn) begin
            count_q <= loadValue;
        end else if (countEvent) begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            thresholdHit <= 1'b0;
        end else begin
            thresholdHit <= countEvent && !loadEn && (count_d == THRESH);
        end
    end

    assign countValue = count_q;

endmodule : stat_counter

// *** frame_event_classify.sv ***
// Turns frame and collision reports into one-cycle counting events.
`timescale 1ns/1ps
module frame_event_classify
    import stat_counters_pkg::*;
#(
    parameter int MIN_CLIENT = MIN_CLIENT_OCTETS,
    parameter int MAX_CLIENT = MAX_CLIENT_OCTETS,
    parameter int SLOT_CYC   = SLOT_CYCLES,
    parameter int SLOT_W     = 12
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Limit
    input  wire logic [15:0] rxLengthLimit,
    // Receive frame report
    input  wire logic        rxFrameDone,
    input  wire logic        rxFrameOk,
    input  wire logic [15:0] rxFrameLength,
    input  wire logic [15:0] rxLengthField,
    input  wire logic [15:0] rxClientOctets,
    input  wire logic        rxIsControl,
    input  wire logic [15:0] rxCtrlOpcode,
    // Transmit
    input  wire logic        txFrameActive,
    input  wire logic        txCollision,
    // Events
    output logic             evOversize,
    output logic             evLenMismatch,
    output logic             evLate,
    output logic             evPause
);

    localparam logic [15:0] MIN_L = 16'(MIN_CLIENT);
    localparam logic [15:0] MAX_L = 16'(MAX_CLIENT);
    localparam logic [SLOT_W-1:0] SLOT_L = SLOT_W'(SLOT_CYC);

    logic [SLOT_W-1:0] slotCnt_q;
    logic              lateWindow;
    logic              inRangeBad;
    logic              shortBad;

    if (SLOT_CYC < 1 || SLOT_CYC >= (1 << SLOT_W) || MIN_CLIENT > MAX_CLIENT) begin : g_bad_param
        $error("frame_event_classify parameters out of range");
    end

    // ======================================================
    // Slot timer from the start of the transmitted frame
    // ======================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slotCnt_q <= '0;
        end else if (!txFrameActive) begin
            slotCnt_q <= '0;
        end else if (slotCnt_q != SLOT_L) begin
            slotCnt_q <= slotCnt_q + SLOT_W'(1);
        end
    end

    assign lateWindow = txFrameActive && (slotCnt_q == SLOT_L);

    // ======================================================
    // Frame classification
    // ======================================================
    assign inRangeBad = (rxLengthField >= MIN_L) && (rxLengthField <= MAX_L)
                        && (rxLengthField != rxClientOctets);
    // A short length is fine when the data is either exact or padded to the minimum.
    assign shortBad   = (rxLengthField < MIN_L) && (rxClientOctets != rxLengthField)
                        && (rxClientOctets != MIN_L);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evOversize    <= 1'b0;
            evLenMismatch <= 1'b0;
            evLate        <= 1'b0;
            evPause       <= 1'b0;
        end else begin
            evOversize    <= rxFrameDone && (rxFrameLength > rxLengthLimit);
            evLenMismatch <= rxFrameDone && (inRangeBad || shortBad);
            evLate        <= txCollision && lateWindow;
            evPause       <= rxFrameDone && rxFrameOk && rxIsControl
                             && (rxCtrlOpcode == PAUSE_OPCODE);
        end
    end

    a_late_window: assert property (@(posedge clk) disable iff (rst)
        txCollision && txFrameActive && (slotCnt_q < SLOT_L) |=> !evLate)
        else $error("collision inside slot time was counted late");

endmodule : frame_event_classify

// *** mac_error_stat_counters.sv ***
// MAC error statistics counters with their host register access.
//
// Notes on behaviour
// - Count received frames longer than length limit.
// - Oversize counter wraps to zero after all-ones.
// - Oversize reaching threshold raises rollover interrupt.
// - Counting needs the global statistics enable.
// - A set mask bit stops its counter.
// - Count in-range length field not matching data.
// - Count short length field not matching data.
// - Length counter wraps to zero after all-ones.
// - Count collisions later than one slot time.
// - Late collision counter wraps after all-ones.
// - Late collision threshold raises rollover interrupt.
// - Count only error-free received pause frames.
// - Pause counter wraps to zero after all-ones.
// - Pause threshold raises rollover interrupt.
`timescale 1ns/1ps
module mac_error_stat_counters
    import stat_counters_pkg::*;
#(
    parameter int MIN_CLIENT = MIN_CLIENT_OCTETS,
    parameter int MAX_CLIENT = MAX_CLIENT_OCTETS,
    parameter int SLOT_CYC   = SLOT_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register access
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [31:0] regWrData,
    output logic      [31:0] regRdData,
    output logic             regRdValid,
    // Control bits held elsewhere
    input  wire logic        statsGlobalOn,
    input  wire logic [3:0]  statsMask,
    input  wire logic [15:0] rxLengthLimit,
    // Receive frame report
    input  wire logic        rxFrameDone,
    input  wire logic        rxFrameOk,
    input  wire logic [15:0] rxFrameLength,
    input  wire logic [15:0] rxLengthField,
    input  wire logic [15:0] rxClientOctets,
    input  wire logic        rxIsControl,
    input  wire logic [15:0] rxCtrlOpcode,
    // Transmit
    input  wire logic        txFrameActive,
    input  wire logic        txCollision,
    // Interrupt status update
    output logic             statsRolloverIrq
);

    // ======================================================
    // Declarations
    // ======================================================
    logic                    evOversize;
    logic                    evLenMismatch;
    logic                    evLate;
    logic                    evPause;
    logic [NUM_COUNTERS-1:0] events;
    logic [NUM_COUNTERS-1:0] countEn;
    logic [NUM_COUNTERS-1:0] wrSel;
    logic [NUM_COUNTERS-1:0] hit;
    logic [15:0]             overCount;
    logic [15:0]             lenCount;
    logic [31:0]             tardyCount;
    logic [15:0]             pauseCount;
    logic [31:0]             regRdData_d;
    logic                    statsRolloverIrq_q;
    logic                    regRdValid_q;
    logic [31:0]             regRdData_q;

    // Decodes a register offset into a one-hot counter select.
    function automatic logic [NUM_COUNTERS-1:0] decodeSel(input logic [7:0] addr);
        logic [NUM_COUNTERS-1:0] sel;
        sel = '0;
        unique case (addr)
            OFS_OVERSIZE: sel[MASK_OVERSIZE] = 1'b1;
            OFS_LENGTH:   sel[MASK_LENGTH]   = 1'b1;
            OFS_TARDY:    sel[MASK_TARDY]    = 1'b1;
            OFS_PAUSE:    sel[MASK_PAUSE]    = 1'b1;
            default:      sel = '0;
        endcase
        return sel;
    endfunction : decodeSel

    // ======================================================
    // Event classification
    // ======================================================
    frame_event_classify #(
        .MIN_CLIENT (MIN_CLIENT),
        .MAX_CLIENT (MAX_CLIENT),
        .SLOT_CYC   (SLOT_CYC),
        .SLOT_W     (12)
    ) u_classify (
        .clk            (clk),
        .rst            (rst),
        .rxLengthLimit  (rxLengthLimit),
        .rxFrameDone    (rxFrameDone),
        .rxFrameOk      (rxFrameOk),
        .rxFrameLength  (rxFrameLength),
        .rxLengthField  (rxLengthField),
        .rxClientOctets (rxClientOctets),
        .rxIsControl    (rxIsControl),
        .rxCtrlOpcode   (rxCtrlOpcode),
        .txFrameActive  (txFrameActive),
        .txCollision    (txCollision),
        .evOversize     (evOversize),
        .evLenMismatch  (evLenMismatch),
        .evLate         (evLate),
        .evPause        (evPause)
    );

    assign events[MASK_OVERSIZE] = evOversize;
    assign events[MASK_LENGTH]   = evLenMismatch;
    assign events[MASK_TARDY]    = evLate;
    assign events[MASK_PAUSE]    = evPause;

    // Enable and mask are sampled when the event reaches the counter, not at frame end.
    assign countEn = events & ~statsMask & {NUM_COUNTERS{statsGlobalOn}};
    assign wrSel   = regWrite ? decodeSel(regAddr) : '0;

    // ======================================================
    // Counters
    // ======================================================
    stat_counter #(.W(16), .RST_VAL(RST_OVERSIZE), .THRESH(THRESH_16)) u_oversize (
        .clk          (clk),
        .rst          (rst),
        .countEvent   (countEn[MASK_OVERSIZE]),
        .loadEn       (wrSel[MASK_OVERSIZE]),
        .loadValue    (regWrData[15:0]),
        .countValue   (overCount),
        .thresholdHit (hit[MASK_OVERSIZE])
    );

    stat_counter #(.W(16), .RST_VAL(RST_LENGTH), .THRESH(THRESH_16)) u_length (
        .clk          (clk),
        .rst          (rst),
        .countEvent   (countEn[MASK_LENGTH]),
        .loadEn       (wrSel[MASK_LENGTH]),
        .loadValue    (regWrData[15:0]),
        .countValue   (lenCount),
        .thresholdHit (hit[MASK_LENGTH])
    );

    stat_counter #(.W(32), .RST_VAL(RST_TARDY), .THRESH(THRESH_32)) u_tardy (
        .clk          (clk),
        .rst          (rst),
        .countEvent   (countEn[MASK_TARDY]),
        .loadEn       (wrSel[MASK_TARDY]),
        .loadValue    (regWrData),
        .countValue   (tardyCount),
        .thresholdHit (hit[MASK_TARDY])
    );

    stat_counter #(.W(16), .RST_VAL(RST_PAUSE), .THRESH(THRESH_16)) u_pause (
        .clk          (clk),
        .rst          (rst),
        .countEvent   (countEn[MASK_PAUSE]),
        .loadEn       (wrSel[MASK_PAUSE]),
        .loadValue    (regWrData[15:0]),
        .countValue   (pauseCount),
        .thresholdHit (hit[MASK_PAUSE])
    );

    // ======================================================
    // Interrupt status update
    // ======================================================
    // One pulse even if several counters cross together; the flag is sticky upstream.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statsRolloverIrq_q <= 1'b0;
        end else begin
            statsRolloverIrq_q <= |hit;
        end
    end

    assign statsRolloverIrq = statsRolloverIrq_q;

    // ======================================================
    // Register read
    // ======================================================
    always_comb begin
        regRdData_d = 32'h00000000;
        unique case (regAddr)
            OFS_OVERSIZE: regRdData_d = {16'h0000, overCount};
            OFS_LENGTH:   regRdData_d = {16'h0000, lenCount};
            OFS_TARDY:    regRdData_d = tardyCount;
            OFS_PAUSE:    regRdData_d = {16'h0000, pauseCount};
            default:      regRdData_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData_q  <= 32'h00000000;
            regRdValid_q <= 1'b0;
        end else begin
            regRdValid_q <= regRead;
            if (regRead) begin
                regRdData_q <= regRdData_d;
            end
        end
    end

    assign regRdData  = regRdData_q;
    assign regRdValid = regRdValid_q;

    // ======================================================
    // Checks
    // ======================================================
    a_oversize_event: assert property (@(posedge clk) disable iff (rst)
        rxFrameDone && (rxFrameLength > rxLengthLimit) && statsGlobalOn && !regWrite
        ##1 !statsMask[MASK_OVERSIZE] && statsGlobalOn && !regWrite
        |=> overCount == $past(overCount) + 16'h0001)
        else $error("oversize frame not counted");

    a_oversize_wrap: assert property (@(posedge clk) disable iff (rst)
        countEn[MASK_OVERSIZE] && !wrSel[MASK_OVERSIZE] && overCount == 16'hffff |=> overCount == 16'h0000)
        else $error("oversize counter did not wrap");

    a_oversize_thresh: assert property (@(posedge clk) disable iff (rst)
        countEn[MASK_OVERSIZE] && !wrSel[MASK_OVERSIZE] && overCount == 16'hbfff |-> ##2 statsRolloverIrq)
        else $error("oversize threshold did not raise interrupt");

    a_global_off: assert property (@(posedge clk) disable iff (rst)
        !statsGlobalOn && !regWrite |=> $stable(overCount) && $stable(lenCount)
        && $stable(tardyCount) && $stable(pauseCount))
        else $error("counter moved while statistics disabled");

    a_mask_hold: assert property (@(posedge clk) disable iff (rst)
        statsMask[MASK_LENGTH] && !wrSel[MASK_LENGTH] |=> $stable(lenCount))
        else $error("masked counter moved");

    a_length_range: assert property (@(posedge clk) disable iff (rst)
        rxFrameDone && rxLengthField >= 16'(MIN_CLIENT) && rxLengthField <= 16'(MAX_CLIENT)
        && rxLengthField != rxClientOctets |=> evLenMismatch)
        else $error("in-range length mismatch missed");

    a_length_short: assert property (@(posedge clk) disable iff (rst)
        rxFrameDone && rxLengthField < 16'(MIN_CLIENT) && rxClientOctets != rxLengthField
        && rxClientOctets != 16'(MIN_CLIENT) |=> evLenMismatch)
        else $error("short length mismatch missed");

    a_length_wrap: assert property (@(posedge clk) disable iff (rst)
        countEn[MASK_LENGTH] && !wrSel[MASK_LENGTH] && lenCount == 16'hffff |=> lenCount == 16'h0000)
        else $error("length counter did not wrap");

    a_tardy_wrap: assert property (@(posedge clk) disable iff (rst)
        countEn[MASK_TARDY] && !wrSel[MASK_TARDY] && tardyCount == 32'hffffffff |=> tardyCount == 32'h0)
        else $error("late collision counter did not wrap");

    a_tardy_thresh: assert property (@(posedge clk) disable iff (rst)
        countEn[MASK_TARDY] && !wrSel[MASK_TARDY] && tardyCount == 32'hbfffffff |-> ##2 statsRolloverIrq)
        else $error("late collision threshold did not raise interrupt");

    a_pause_only: assert property (@(posedge clk) disable iff (rst)
        evPause |-> $past(rxFrameDone && rxFrameOk && rxIsControl && rxCtrlOpcode == PAUSE_OPCODE))
        else $error("non-pause or errored frame counted");

    a_pause_wrap: assert property (@(posedge clk) disable iff (rst)
        countEn[MASK_PAUSE] && !wrSel[MASK_PAUSE] && pauseCount == 16'hffff |=> pauseCount == 16'h0000)
        else $error("pause counter did not wrap");

    a_pause_thresh: assert property (@(posedge clk) disable iff (rst)
        countEn[MASK_PAUSE] && !wrSel[MASK_PAUSE] && pauseCount == 16'hbfff |-> ##2 statsRolloverIrq)
        else $error("pause threshold did not raise interrupt");

    a_length_thresh: assert property (@(posedge clk) disable iff (rst)
        countEn[MASK_LENGTH] && !wrSel[MASK_LENGTH] && lenCount == 16'hbfff |-> ##2 statsRolloverIrq)
        else $error("length threshold did not raise interrupt");

    a_write_load: assert property (@(posedge clk) disable iff (rst)
        regWrite && regAddr == OFS_TARDY |=> tardyCount == $past(regWrData))
        else $error("write did not load counter");

    a_write_wins: assert property (@(posedge clk) disable iff (rst)
        wrSel[MASK_OVERSIZE] |=> overCount == $past(regWrData[15:0]))
        else $error("software write lost to a counting event");

    a_mask_oversize: assert property (@(posedge clk) disable iff (rst)
        statsMask[MASK_OVERSIZE] && !wrSel[MASK_OVERSIZE] |=> $stable(overCount))
        else $error("masked oversize counter moved");

    a_mask_tardy: assert property (@(posedge clk) disable iff (rst)
        statsMask[MASK_TARDY] && !wrSel[MASK_TARDY] |=> $stable(tardyCount))
        else $error("masked late collision counter moved");

    a_mask_pause: assert property (@(posedge clk) disable iff (rst)
        statsMask[MASK_PAUSE] && !wrSel[MASK_PAUSE] |=> $stable(pauseCount))
        else $error("masked pause counter moved");

    a_late_count: assert property (@(posedge clk) disable iff (rst)
        evLate && countEn[MASK_TARDY] && !wrSel[MASK_TARDY] |=> tardyCount == $past(tardyCount) + 32'h00000001)
        else $error("late collision not counted");

    a_read_tardy: assert property (@(posedge clk) disable iff (rst)
        regRead && regAddr == OFS_TARDY |=> regRdValid && regRdData == $past(tardyCount))
        else $error("read did not return the late collision count");

endmodule : mac_error_stat_counters

// *** mac_error_stat_counters_test.sv ***
// Self-checking testbench for the MAC error statistics counters.
`timescale 1ns/1ps
module mac_error_stat_counters_test import stat_counters_pkg::*;;
    // ==========================================================
    // Signals and bookkeeping
    // ==========================================================
    localparam int SLOT = 8;
    logic        clk, rst, regWrite, regRead, regRdValid, statsGlobalOn, rxFrameDone, rxFrameOk;
    logic        rxIsControl, txFrameActive, txCollision, statsRolloverIrq;
    logic [7:0]  regAddr;
    logic [31:0] regWrData, regRdData, rd;
    logic [3:0]  statsMask;
    logic [15:0] rxLengthLimit, rxFrameLength, rxLengthField, rxClientOctets, rxCtrlOpcode;
    logic [31:0] expVal [4];
    logic [7:0]  ofs [4] = '{OFS_OVERSIZE, OFS_LENGTH, OFS_TARDY, OFS_PAUSE};
    int          errTotal, samplesChecked, irqCount, i0;

    mac_error_stat_counters #(.SLOT_CYC(SLOT)) dut (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .statsGlobalOn(statsGlobalOn), .statsMask(statsMask), .rxLengthLimit(rxLengthLimit),
        .rxFrameDone(rxFrameDone), .rxFrameOk(rxFrameOk), .rxFrameLength(rxFrameLength),
        .rxLengthField(rxLengthField), .rxClientOctets(rxClientOctets), .rxIsControl(rxIsControl),
        .rxCtrlOpcode(rxCtrlOpcode), .txFrameActive(txFrameActive), .txCollision(txCollision),
        .statsRolloverIrq(statsRolloverIrq)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;
    always @(posedge clk) if (statsRolloverIrq === 1'b1) irqCount <= irqCount + 1;

    // ==========================================================
    // Access tasks and comparisons
    // ==========================================================
    task automatic report_and_stop();
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check32(input string what, input logic [31:0] expv, input logic [31:0] got);
        samplesChecked++;
        if (got !== expv) begin
            errTotal++;
            $display("unexpected %s: expected %h, seen %h", what, expv, got);
        end
    endtask : check32

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : reg_write

    // The answer is awaited for a few cycles only, so a missing reply shows as a mismatch.
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        int n;
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        n = 0;
        while (regRdValid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        check32("regRdValid", 32'h00000001, {31'h0, regRdValid});
        d = regRdData;
    endtask : reg_read

    task automatic check_all();
        for (int k = 0; k < 4; k++) begin
            reg_read(ofs[k], rd);
            check32($sformatf("counter at %h", ofs[k]), expVal[k], rd);
        end
    endtask : check_all

    task automatic frame(input logic [15:0] len, fld, oct, input logic ctl, input logic [15:0] opc,
                         input logic ok);
        @(posedge clk);
        rxFrameLength  <= len;
        rxLengthField  <= fld;
        rxClientOctets <= oct;
        rxIsControl    <= ctl;
        rxCtrlOpcode   <= opc;
        rxFrameOk      <= ok;
        rxFrameDone    <= 1'b1;
        @(posedge clk);
        rxFrameDone <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : frame

    task automatic collide(input int n);
        @(posedge clk);
        txFrameActive <= 1'b1;
        repeat (n) @(posedge clk);
        txCollision <= 1'b1;
        @(posedge clk);
        txCollision   <= 1'b0;
        txFrameActive <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : collide

    // One counting event of kind k: oversize, length mismatch, late collision, pause.
    task automatic fire(input int k);
        case (k)
            0: frame(16'h05ef, 16'h0800, 16'h05e1, 1'b0, 16'h0000, 1'b1);
            1: frame(16'h0064, 16'h0064, 16'h005a, 1'b0, 16'h0000, 1'b1);
            2: collide(SLOT + 2);
            default: frame(16'h0040, 16'h8808, 16'h002e, 1'b1, PAUSE_OPCODE, 1'b1);
        endcase
    endtask : fire

    function automatic logic [31:0] top(input int k);
        return (k == 2) ? 32'hffffffff : 32'h0000ffff;
    endfunction : top

    function automatic logic [31:0] thr(input int k);
        return (k == 2) ? THRESH_32 : {16'h0000, THRESH_16};
    endfunction : thr

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial begin
        {rst, regWrite, regRead, rxFrameDone, rxFrameOk, rxIsControl, txFrameActive, txCollision} = 8'h80;
        {regAddr, regWrData, rxFrameLength, rxLengthField, rxClientOctets, rxCtrlOpcode} = '0;
        statsGlobalOn = 1'b1;
        statsMask     = 4'h0;
        rxLengthLimit = 16'h05ee;
        errTotal = 0;
        samplesChecked = 0;
        irqCount = 0;
        for (int k = 0; k < 4; k++) expVal[k] = 32'h00000000;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check_all();
        reg_write(8'hd0, 32'h12345678);
        reg_read(8'hd0, rd);
        check32("unmapped read", 32'h00000000, rd);
        check_all();
        for (int k = 0; k < 4; k++) begin
            fire(k);
            expVal[k] = expVal[k] + 1;
        end
        check_all();
        // Near misses: none of these may count, except the short mismatched field.
        frame(16'h05ee, 16'h0800, 16'h05e0, 1'b0, 16'h0000, 1'b1);
        frame(16'h0064, 16'h0064, 16'h0064, 1'b0, 16'h0000, 1'b1);
        frame(16'h0040, 16'h001e, 16'h0028, 1'b0, 16'h0000, 1'b1);
        expVal[1] = expVal[1] + 1;
        frame(16'h0040, 16'h001e, 16'h002e, 1'b0, 16'h0000, 1'b1);
        frame(16'h0040, 16'h8808, 16'h002e, 1'b1, 16'h0002, 1'b1);
        frame(16'h0040, 16'h8808, 16'h002e, 1'b1, PAUSE_OPCODE, 1'b0);
        collide(2);
        check_all();
        @(posedge clk) statsGlobalOn <= 1'b0;
        for (int k = 0; k < 4; k++) fire(k);
        @(posedge clk) statsGlobalOn <= 1'b1;
        check_all();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) statsMask <= 4'h1 << k;
            for (int j = 0; j < 4; j++) begin
                fire(j);
                if (j != k) expVal[j] = expVal[j] + 1;
            end
        end
        @(posedge clk) statsMask <= 4'h0;
        check_all();
        for (int k = 0; k < 4; k++) begin
            reg_write(ofs[k], top(k));
            fire(k);
            expVal[k] = 32'h00000000;
        end
        check_all();
        for (int k = 0; k < 4; k++) begin
            i0 = irqCount;
            reg_write(ofs[k], thr(k));
            repeat (6) @(posedge clk);
            check32("irq on write", 32'h00000000, irqCount - i0);
            reg_write(ofs[k], thr(k) - 32'h00000001);
            fire(k);
            repeat (2) @(posedge clk);
            check32("irq pulses", 32'h00000001, irqCount - i0);
            expVal[k] = thr(k);
        end
        check_all();
        report_and_stop();
    end

    // The whole sequence needs well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        report_and_stop();
    end
endmodule : mac_error_stat_counters_test
